//--- design/rmiw_pkg.sv
// Package of constants and carrier types for the receive info word builder.
package rmiw_pkg;
	localparam int          RMIW_AXI_AW       = 8;
	localparam int          RMIW_RAM_AW       = 13;
	// Register byte offsets.
	localparam logic [7:0]  RMIW_OFS_CTRL     = 8'h00;
	localparam logic [7:0]  RMIW_OFS_IRQ_STAT = 8'h04;
	localparam logic [7:0]  RMIW_OFS_IRQ_MASK = 8'h08;
	localparam logic [7:0]  RMIW_OFS_LAST     = 8'h0C;
	localparam logic [7:0]  RMIW_OFS_COUNT    = 8'h10;
	// Control register fields and reset value.
	localparam int          RMIW_CTRL_EN      = 0;
	localparam int          RMIW_CTRL_BUSY    = 1;
	localparam logic [1:0]  RMIW_CTRL_RST     = 2'h1;
	// Interrupt status and mask fields.
	localparam int          RMIW_IRQ_W        = 4;
	localparam int          RMIW_IRQ_DONE     = 0;
	localparam int          RMIW_IRQ_MESSAGE_ERROR_FLAG     = 1;
	localparam int          RMIW_IRQ_BUSY     = 2;
	localparam int          RMIW_IRQ_ILL      = 3;
	localparam logic [3:0]  RMIW_MASK_RST     = 4'h0;
	// Information word bit positions.
	localparam int          RMIW_B_TMO        = 15;
	localparam int          RMIW_B_IWD        = 14;
	localparam int          RMIW_B_GAP        = 13;
	localparam int          RMIW_B_WCT        = 12;
	localparam int          RMIW_B_SYN        = 11;
	localparam int          RMIW_B_MESSAGE_ERROR_FLAG       = 10;
	localparam int          RMIW_B_BUSY       = 9;
	localparam int          RMIW_B_ILL        = 8;
	localparam int          RMIW_B_TXERR      = 7;
	localparam int          RMIW_B_TERMINAL_PAIR_TRANSFER_FLAG       = 6;
	localparam int          RMIW_B_BUS        = 5;
	// Command word layout and special values.
	localparam logic [4:0]  RMIW_RT_BCAST     = 5'h1F;
	localparam logic [4:0]  RMIW_SA_MODE0     = 5'h00;
	localparam logic [4:0]  RMIW_SA_MODE1     = 5'h1F;
	localparam int          RMIW_CW_TR        = 10;
	localparam logic [5:0]  RMIW_WC_FULL      = 6'h20;
	// Data words follow the info and time-tag words of the record.
	localparam logic [12:0] RMIW_DATA_OFS     = 13'h0002;
	// AXI responses.
	localparam logic [1:0]  RMIW_RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RMIW_RESP_SLVERR  = 2'h2;

	typedef struct packed {
		logic [15:0] first_command_word;
		logic [15:0] second_command_word;
		logic        rt_to_rt;
		logic        bus_select_flag;
		logic        illegal_entry;
		logic        per_command_force_busy;
		logic [12:0] record_base;
	} rmiw_cmd_s;

	typedef struct packed {
		logic        valid;
		logic [15:0] data;
		logic        coding_error;
		logic        sync_error;
	} rmiw_word_s;

	typedef struct packed {
		logic        valid;
		logic        parity_ok;
		logic [15:0] data;
	} rmiw_stat_s;

	typedef enum logic [2:0] {
		RMIW_IDLE  = 3'b001,
		RMIW_RECV  = 3'b010,
		RMIW_WRITE = 3'b100
	} rmiw_state_e;
endpackage : rmiw_pkg

//--- design/rmiw_builder.sv
// Receive message information word builder with AXI4-Lite registers.
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
// Overview of operation
// - Message error bit 10 is set when bit 7 or bits 11-15 are set.
// - Busy bit 9 set on busy reply from global busy or force-busy.
// - Data words are stored normally even when answering busy.
// - Illegal command bit 8 set when the table entry for the command is one.
// - RT-to-RT: transmitter error bit 7 if second command is to address 31.
// - RT-to-RT: transmitter error if second command T/R bit is zero.
// - RT-to-RT: transmitter error if second subaddress is 00000 or 11111.
// - RT-to-RT: tx error if both commands share a non-broadcast address.
// - Transmitter error when the returned status word is invalid.
// - Tx error when status address 15:11 differs from second command.
// - Bit 6 set only for an error-free RT-to-RT receive.
// - Bit 5 is 0 for bus A and 1 for bus B.
// - Bits 4-0 copy the word count; zero means 32 words.
// - Bit 15 set when the RT-to-RT transmitter times out.
// - Bit 14 set on Manchester or parity error in a data word.
// - Bit 12 set when fewer data words arrive than commanded.
// - Bit 11 set when a data word carries command/status sync.
module rmiw_builder
	import rmiw_pkg::*;
#(
	parameter int AXI_AW = RMIW_AXI_AW
) (
	input  wire logic                  mclk,
	input  wire logic                  nrst,
	input  wire logic                  msg_start,
	input  wire rmiw_pkg::rmiw_cmd_s   msg_cmd,
	input  wire rmiw_pkg::rmiw_word_s  rx_word,
	input  wire rmiw_pkg::rmiw_stat_s  tx_status,
	input  wire logic                  tx_timeout,
	input  wire logic                  gap_error,
	input  wire logic                  msg_end,
	output logic                       ram_we,
	output logic [RMIW_RAM_AW-1:0]     ram_addr,
	output logic [15:0]                ram_wdata,
	output logic                       busy_status,
	output logic                       irq,
	input  wire logic [AXI_AW-1:0]     s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [AXI_AW-1:0]     s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready
);
	import rmiw_pkg::*;

	generate
		if (AXI_AW < 5 || AXI_AW > 8) begin : g_bad_aw
			$error("AXI_AW must lie between 5 and 8.");
		end
	endgenerate

	// Checks the second command word of an RT-to-RT receive.
	function automatic logic cw2_bad(input logic [15:0] cw1,
	                                 input logic [15:0] cw2);
		logic bad;
		bad = (cw2[15:11] == RMIW_RT_BCAST);
		bad = bad | ~cw2[RMIW_CW_TR];
		bad = bad | (cw2[9:5] == RMIW_SA_MODE0)
		          | (cw2[9:5] == RMIW_SA_MODE1);
		bad = bad | ((cw2[15:11] == cw1[15:11])
		          & (cw1[15:11] != RMIW_RT_BCAST));
		return bad;
	endfunction : cw2_bad

	rmiw_state_e      state,     next_state;
	rmiw_cmd_s        cmd,       next_cmd;
	logic [5:0]       rcvd,      next_rcvd;
	logic [4:0]       errs,      next_errs;   // Bits 15 down to 11.
	logic             txerr,     next_txerr;
	logic             busy_f,    next_busy_f;
	logic             next_ram_we;
	logic [12:0]      next_ram_addr;
	logic [15:0]      next_ram_wdata;
	logic [15:0]      last_info, next_last_info;
	logic [15:0]      msg_cnt,   next_msg_cnt;
	logic [RMIW_IRQ_W-1:0] ev_set;
	logic [5:0]       wc_exp;
	logic [4:0]       fin_errs;
	logic             fin_message_error_flag;
	logic [15:0]      fin_word;

	logic [1:0]       ctrl;
	logic [RMIW_IRQ_W-1:0] irq_stat, irq_mask;

	always_comb begin
		wc_exp   = (cmd.first_command_word[4:0] == 5'h00) ? RMIW_WC_FULL
		         : {1'b0, cmd.first_command_word[4:0]};
		fin_errs = errs;
		if (rcvd < wc_exp) begin
			fin_errs[RMIW_B_WCT-RMIW_B_SYN] = 1'b1;
		end
		fin_message_error_flag = |fin_errs | txerr;
		fin_word = 16'h0000;
		fin_word[15:11]       = fin_errs;
		fin_word[RMIW_B_MESSAGE_ERROR_FLAG] = fin_message_error_flag;
		fin_word[RMIW_B_BUSY] = busy_f;
		fin_word[RMIW_B_ILL]  = cmd.illegal_entry;
		fin_word[RMIW_B_TXERR] = txerr;
		fin_word[RMIW_B_TERMINAL_PAIR_TRANSFER_FLAG] = cmd.rt_to_rt & ~fin_message_error_flag;
		fin_word[RMIW_B_BUS]  = cmd.bus_select_flag;
		fin_word[4:0]         = cmd.first_command_word[4:0];
	end

	always_comb begin
		next_state     = state;
		next_cmd       = cmd;
		next_rcvd      = rcvd;
		next_errs      = errs;
		next_txerr     = txerr;
		next_busy_f    = busy_f;
		next_ram_we    = 1'b0;
		next_ram_addr  = ram_addr;
		next_ram_wdata = ram_wdata;
		next_last_info = last_info;
		next_msg_cnt   = msg_cnt;
		ev_set         = '0;
		unique case (state)
			RMIW_IDLE: begin
				if (msg_start && ctrl[RMIW_CTRL_EN]) begin
					next_cmd    = msg_cmd;
					next_rcvd   = 6'h00;
					next_errs   = 5'h00;
					next_busy_f = ctrl[RMIW_CTRL_BUSY]
					            | msg_cmd.per_command_force_busy;
					next_txerr  = msg_cmd.rt_to_rt
					            & cw2_bad(msg_cmd.first_command_word,
					                      msg_cmd.second_command_word);
					next_state  = RMIW_RECV;
				end
			end
			RMIW_RECV: begin
				// Data words go to the buffer even under busy.
				if (rx_word.valid && rcvd < wc_exp) begin
					next_ram_we    = 1'b1;
					next_ram_addr  = cmd.record_base + RMIW_DATA_OFS
					               + {7'h00, rcvd};
					next_ram_wdata = rx_word.data;
					next_rcvd      = rcvd + 6'h01;
				end
				if (rx_word.valid && rx_word.coding_error) begin
					next_errs[RMIW_B_IWD-RMIW_B_SYN] = 1'b1;
				end
				if (rx_word.valid && rx_word.sync_error) begin
					next_errs[0] = 1'b1;
				end
				if (gap_error) begin
					next_errs[RMIW_B_GAP-RMIW_B_SYN] = 1'b1;
				end
				if (cmd.rt_to_rt && tx_timeout) begin
					next_errs[RMIW_B_TMO-RMIW_B_SYN] = 1'b1;
				end
				if (cmd.rt_to_rt && tx_status.valid
				    && (!tx_status.parity_ok
				        || tx_status.data[15:11]
				           != cmd.second_command_word[15:11])) begin
					next_txerr = 1'b1;
				end
				if (msg_end) begin
					next_state = RMIW_WRITE;
				end
			end
			RMIW_WRITE: begin
				next_ram_we    = 1'b1;
				next_ram_addr  = cmd.record_base;
				next_ram_wdata = fin_word;
				next_last_info = fin_word;
				next_msg_cnt   = msg_cnt + 16'h0001;
				ev_set[RMIW_IRQ_DONE] = 1'b1;
				ev_set[RMIW_IRQ_MESSAGE_ERROR_FLAG] = fin_message_error_flag;
				ev_set[RMIW_IRQ_BUSY] = busy_f;
				ev_set[RMIW_IRQ_ILL]  = cmd.illegal_entry;
				next_state     = RMIW_IDLE;
			end
			default: begin
				next_state = RMIW_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			state       <= RMIW_IDLE;
			cmd         <= '0;
			rcvd        <= 6'h00;
			errs        <= 5'h00;
			txerr       <= 1'b0;
			busy_f      <= 1'b0;
			ram_we      <= 1'b0;
			ram_addr    <= 13'h0000;
			ram_wdata   <= 16'h0000;
			last_info   <= 16'h0000;
			msg_cnt     <= 16'h0000;
			busy_status <= 1'b0;
		end else begin
			state       <= next_state;
			cmd         <= next_cmd;
			rcvd        <= next_rcvd;
			errs        <= next_errs;
			txerr       <= next_txerr;
			busy_f      <= next_busy_f;
			ram_we      <= next_ram_we;
			ram_addr    <= next_ram_addr;
			ram_wdata   <= next_ram_wdata;
			last_info   <= next_last_info;
			msg_cnt     <= next_msg_cnt;
			busy_status <= next_busy_f;
		end
	end

	// Register slave: address and data are caught separately, then answered.
	logic              aw_hold,  next_aw_hold;
	logic              w_hold,   next_w_hold;
	logic [7:0]        aw_addr,  next_aw_addr;
	logic [31:0]       w_data,   next_w_data;
	logic [3:0]        w_strb,   next_w_strb;
	logic              next_bvalid, next_rvalid;
	logic [1:0]        next_bresp,  next_rresp;
	logic [31:0]       next_rdata;
	logic [1:0]        next_ctrl;
	logic [RMIW_IRQ_W-1:0] next_irq_stat, next_irq_mask;
	logic [7:0]        ar_addr;

	always_comb begin
		next_aw_hold  = aw_hold;
		next_w_hold   = w_hold;
		next_aw_addr  = aw_addr;
		next_w_data   = w_data;
		next_w_strb   = w_strb;
		next_bvalid   = s_axi_bvalid;
		next_bresp    = s_axi_bresp;
		next_rvalid   = s_axi_rvalid;
		next_rresp    = s_axi_rresp;
		next_rdata    = s_axi_rdata;
		next_ctrl     = ctrl;
		next_irq_mask = irq_mask;
		next_irq_stat = irq_stat;
		ar_addr       = 8'(s_axi_araddr) & 8'hFC;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_hold = 1'b1;
			next_aw_addr = 8'(s_axi_awaddr) & 8'hFC;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_hold = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (aw_hold && w_hold && !s_axi_bvalid) begin
			next_aw_hold = 1'b0;
			next_w_hold  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = RMIW_RESP_OKAY;
			unique case (aw_addr)
				RMIW_OFS_CTRL: begin
					if (w_strb[0]) begin
						next_ctrl = w_data[1:0];
					end
				end
				RMIW_OFS_IRQ_MASK: begin
					if (w_strb[0]) begin
						next_irq_mask = w_data[RMIW_IRQ_W-1:0];
					end
				end
				RMIW_OFS_IRQ_STAT, RMIW_OFS_LAST, RMIW_OFS_COUNT: begin
				end
				default: begin
					next_bresp = RMIW_RESP_SLVERR;
				end
			endcase
		end
		if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp  = RMIW_RESP_OKAY;
			next_rdata  = 32'h0000_0000;
			unique case (ar_addr)
				RMIW_OFS_CTRL:     next_rdata[1:0] = ctrl;
				RMIW_OFS_IRQ_MASK: next_rdata[RMIW_IRQ_W-1:0] = irq_mask;
				RMIW_OFS_LAST:     next_rdata[15:0] = last_info;
				RMIW_OFS_COUNT:    next_rdata[15:0] = msg_cnt;
				RMIW_OFS_IRQ_STAT: begin
					next_rdata[RMIW_IRQ_W-1:0] = irq_stat;
					next_irq_stat = '0;
				end
				default:           next_rresp = RMIW_RESP_SLVERR;
			endcase
		end
		// A new event wins over a clearing read in the same cycle.
		next_irq_stat = next_irq_stat | ev_set;
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			aw_hold       <= 1'b0;
			w_hold        <= 1'b0;
			aw_addr       <= 8'h00;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_arready <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RMIW_RESP_OKAY;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= RMIW_RESP_OKAY;
			s_axi_rdata   <= 32'h0000_0000;
			ctrl          <= RMIW_CTRL_RST;
			irq_mask      <= RMIW_MASK_RST;
			irq_stat      <= '0;
			irq           <= 1'b0;
		end else begin
			aw_hold       <= next_aw_hold;
			w_hold        <= next_w_hold;
			aw_addr       <= next_aw_addr;
			w_data        <= next_w_data;
			w_strb        <= next_w_strb;
			s_axi_awready <= !next_aw_hold;
			s_axi_wready  <= !next_w_hold;
			s_axi_arready <= !next_rvalid;
			s_axi_bvalid  <= next_bvalid;
			s_axi_bresp   <= next_bresp;
			s_axi_rvalid  <= next_rvalid;
			s_axi_rresp   <= next_rresp;
			s_axi_rdata   <= next_rdata;
			ctrl          <= next_ctrl;
			irq_mask      <= next_irq_mask;
			irq_stat      <= next_irq_stat;
			irq           <= |(next_irq_stat & next_irq_mask);
		end
	end
endmodule : rmiw_builder

//--- tb/rmiw_chk.sv
// Port checker for the receive info word builder.
`timescale 1ns/1ps
module rmiw_chk
	import rmiw_pkg::*;
(
	input wire logic                                 mclk,
	input wire logic                                 nrst,
	input wire logic                                 msg_start,
	input wire rmiw_pkg::rmiw_cmd_s                  msg_cmd,
	input wire rmiw_pkg::rmiw_word_s                 rx_word,
	input wire logic                                 msg_end,
	input wire logic                                 ram_we,
	input wire logic [rmiw_pkg::RMIW_RAM_AW-1:0]     ram_addr,
	input wire logic [15:0]                          ram_wdata,
	input wire logic                                 busy_status
);
	import rmiw_pkg::*;
	rmiw_cmd_s   cmd, next_cmd;
	logic        act, next_act;
	logic [5:0]  cnt, next_cnt, wcn;
	logic [15:0] c1, c2;
	logic        info, bad2;
	// The command is held from its start so that the info write can be judged.
	always_comb begin
		next_cmd = cmd;
		next_act = act;
		next_cnt = cnt;
		if (msg_start && !act) begin
			next_cmd = msg_cmd;
			next_act = 1'b1;
			next_cnt = 6'h00;
		end else if (act && rx_word.valid) begin
			next_cnt = cnt + 6'h01;
		end
		if (msg_end) begin
			next_act = 1'b0;
		end
		if (!nrst) begin
			next_cmd = '0;
			next_act = 1'b0;
			next_cnt = 6'h00;
		end
	end
	always_ff @(posedge mclk) begin
		cmd <= next_cmd;
		act <= next_act;
		cnt <= next_cnt;
	end
	assign c1 = cmd.first_command_word;
	assign c2 = cmd.second_command_word;
	assign wcn = (c1[4:0] == 5'h00) ? RMIW_WC_FULL : {1'b0, c1[4:0]};
	assign info = ram_we && ram_addr == cmd.record_base;
	assign bad2 = cmd.rt_to_rt && (c2[15:11] == RMIW_RT_BCAST
		|| !c2[RMIW_CW_TR] || c2[9:5] == RMIW_SA_MODE0
		|| c2[9:5] == RMIW_SA_MODE1 || c2[15:11] == c1[15:11]);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	property p_message_error_flag;
		info |-> ram_wdata[10] == (|{ram_wdata[15:11], ram_wdata[7]});
	endproperty
	a_message_error_flag: assert property (p_message_error_flag)
		else $error("bad error summary");
	property p_busy;
		info |-> ram_wdata[9] == busy_status
			&& (busy_status || !cmd.per_command_force_busy);
	endproperty
	a_busy: assert property (p_busy)
		else $error("bad busy bit");
	property p_data;
		act && rx_word.valid && !rx_word.coding_error
			&& !rx_word.sync_error && cnt < wcn
		|=> ram_we && ram_wdata == $past(rx_word.data)
			&& ram_addr == cmd.record_base + RMIW_DATA_OFS + $past(cnt);
	endproperty
	a_data: assert property (p_data)
		else $error("data not stored");
	property p_ill;
		info |-> ram_wdata[8] == cmd.illegal_entry;
	endproperty
	a_ill: assert property (p_ill)
		else $error("bad illegal bit");
	property p_cw2;
		info && bad2 |-> ram_wdata[7] && !ram_wdata[6];
	endproperty
	a_cw2: assert property (p_cw2)
		else $error("no tx error");
	property p_terminal_pair_transfer_flag;
		info |-> ram_wdata[6] == (cmd.rt_to_rt && !ram_wdata[10]);
	endproperty
	a_terminal_pair_transfer_flag: assert property (p_terminal_pair_transfer_flag)
		else $error("bad pair bit");
	property p_bus;
		info |-> ram_wdata[5] == cmd.bus_select_flag;
	endproperty
	a_bus: assert property (p_bus)
		else $error("bad bus bit");
	property p_wc;
		info |-> ram_wdata[4:0] == c1[4:0];
	endproperty
	a_wc: assert property (p_wc)
		else $error("bad word count");
	property p_info;
		msg_end && act |-> ##1 !ram_we ##1 info;
	endproperty
	a_info: assert property (p_info)
		else $error("info write late");
	c_terminal_pair_transfer_flag: cover property (info && ram_wdata[6]);
	c_busy: cover property (info && ram_wdata[9]);
	c_err: cover property (info && ram_wdata[10]);
endmodule : rmiw_chk

//--- tb/rmiw_far_end.sv
// Model of the bus controller and the transmitting terminal.
`timescale 1ns/1ps
module rmiw_far_end
	import rmiw_pkg::*;
(
	input wire logic             mclk,
	output logic                 msg_start,
	output rmiw_pkg::rmiw_cmd_s  msg_cmd,
	output rmiw_pkg::rmiw_word_s rx_word,
	output rmiw_pkg::rmiw_stat_s tx_status,
	output logic                 tx_timeout,
	output logic                 gap_error,
	output logic                 msg_end
);
	import rmiw_pkg::*;
	initial begin
		msg_start = 1'b0;
		msg_cmd = '0;
		rx_word = '0;
		tx_status = '0;
		tx_timeout = 1'b0;
		gap_error = 1'b0;
		msg_end = 1'b0;
	end
	// The caller sets the table entry only when it tests detection.
	task automatic run(input rmiw_cmd_s c, input int n,
		input logic [15:0] sw, input logic sok, tmo, ce, se, gp);
		@(posedge mclk);
		msg_start <= 1'b1;
		msg_cmd <= c;
		@(posedge mclk);
		msg_start <= 1'b0;
		msg_cmd <= ~c;
		gap_error <= gp;
		if (c.rt_to_rt && tmo) begin
			tx_timeout <= 1'b1;
		end else if (c.rt_to_rt) begin
			tx_status <= '{1'b1, sok, sw};
		end
		@(posedge mclk);
		tx_timeout <= 1'b0;
		gap_error <= 1'b0;
		tx_status <= '{1'b0, ~sok, ~sw};
		for (int i = 0; i < n; i++) begin
			rx_word <= '{1'b1, 16'hA500 + 16'(i), ce && i == 0, se && i == n - 1};
			@(posedge mclk);
		end
		rx_word <= '{1'b0, ~rx_word.data, 1'b0, 1'b0};
		msg_end <= 1'b1;
		@(posedge mclk);
		msg_end <= 1'b0;
	endtask : run
endmodule : rmiw_far_end

//--- tb/tb_rmiw_builder.sv
// Self-checking bench for the receive info word builder.
`timescale 1ns/1ps
module tb_rmiw_builder;
	import rmiw_pkg::*;
	logic mclk = 1'b0, nrst = 1'b0, msg_start, tx_timeout, msg_end, gap_error;
	logic ram_we, busy_status, irq, gb = 1'b0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'hF, mk = 4'h0;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [12:0] ram_addr, qa[$];
	logic [15:0] ram_wdata, qd[$];
	logic [15:0] bad2[5] = '{16'hFC64, 16'h2864, 16'h2C04, 16'h2FE4, 16'h1C64};
	logic [9:0] fl[8] = '{10'h081, 10'h101, 10'h011, 10'h020,
		10'h040, 10'h004, 10'h008, 10'h200};
	rmiw_cmd_s msg_cmd;
	rmiw_word_s rx_word;
	rmiw_stat_s tx_status;
	int n_fail = 0, num_checks = 0, nmsg = 0;
	always #5 mclk = ~mclk;
	rmiw_builder i_dut(.mclk, .nrst, .msg_start, .msg_cmd, .rx_word,
		.tx_status, .tx_timeout, .gap_error, .msg_end, .ram_we,
		.ram_addr, .ram_wdata, .busy_status, .irq, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	rmiw_far_end i_far(.mclk, .msg_start, .msg_cmd, .rx_word, .tx_status,
		.tx_timeout, .gap_error, .msg_end);
	always @(posedge mclk) begin
		if (ram_we) begin
			qa.push_back(ram_addr);
			qd.push_back(ram_wdata);
		end
	end
	task chk(input string nm, input logic [31:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s exp %h got %h", nm, exp, got);
		end
	endtask : chk
	task axw(input logic [7:0] a, input logic [31:0] v);
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge mclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axw
	task axr(input logic [7:0] a);
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge mclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axr
	task rd(input logic [7:0] a, input logic [31:0] e);
		axr(a);
		chk("rdata", d, e);
		chk("rresp", r, RMIW_RESP_OKAY);
	endtask : rd
	task msg(input logic [15:0] c1, c2, input logic [9:0] f, input int n);
		rmiw_cmd_s c;
		logic [15:0] e, g;
		logic [5:0] wcn;
		logic tx, mr;
		c = '{c1, c2, f[0], f[1], f[2], f[3], 13'(256 + nmsg * 64)};
		wcn = (c1[4:0] == 5'h00) ? 6'h20 : {1'b0, c1[4:0]};
		tx = f[0] && (c2[15:11] == 5'h1F || !c2[10] || c2[9:5] == 5'h00
			|| c2[9:5] == 5'h1F || c2[15:11] == c1[15:11] || f[7] || f[8]);
		mr = f[4] | f[5] | f[6] | f[9] | (n < wcn) | tx;
		e = {f[4], f[5], f[9], (n < wcn), f[6], mr, f[3] | gb, f[2], tx,
			f[0] & ~mr, f[1], c1[4:0]};
		qa.delete();
		qd.delete();
		i_far.run(c, n, {c2[15:11] ^ {5{f[8]}}, 11'h000}, !f[7], f[4],
			f[5], f[6], f[9]);
		while (!(qa.size() > 0 && qa[$] === c.record_base)) @(negedge mclk);
		g = qd[$];
		chk("info tmo iwd", g[15:13], e[15:13]);
		chk("info wct syn", g[12:11], e[12:11]);
		chk("info message_error_flag", g[10], e[10]);
		chk("info mid", g[9:7], e[9:7]);
		chk("info txerr", g[7], e[7]);
		chk("info lo", g[6:0], e[6:0]);
		if (!mr && !f[2]) begin
			for (int i = 0; i < n; i++) begin
				chk("daddr", qa[i], c.record_base + 13'h2 + 13'(i));
				chk("ddata", qd[i], 16'hA500 + 16'(i));
			end
		end
		@(negedge mclk);
		chk("irq", irq, mk != 4'h0);
		nmsg++;
		rd(RMIW_OFS_LAST, {16'h0, e});
		rd(RMIW_OFS_COUNT, nmsg);
		rd(RMIW_OFS_IRQ_STAT,
		   {28'h0, f[2], f[3] | gb, mr, 1'b1});
		rd(RMIW_OFS_IRQ_STAT, 0);
		chk("irq clr", irq, 1'b0);
	endtask : msg
	task print_verdict;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : print_verdict
	initial begin
		#100000;
		n_fail++;
		print_verdict;
	end
	initial begin
		repeat (3) @(posedge mclk);
		nrst <= 1'b1;
		rd(RMIW_OFS_CTRL, RMIW_CTRL_RST);
		rd(RMIW_OFS_IRQ_MASK, RMIW_MASK_RST);
		axr(8'h14);
		chk("bad rd", d, 0);
		chk("bad rresp", r, RMIW_RESP_SLVERR);
		axw(8'h14, 32'hF);
		chk("bad bresp", r, RMIW_RESP_SLVERR);
		msg(16'h1844, 16'h0000, 10'h000, 4);
		axw(RMIW_OFS_IRQ_MASK, 32'hF);
		chk("bresp", r, RMIW_RESP_OKAY);
		rd(RMIW_OFS_IRQ_MASK, 32'hF);
		mk = 4'hF;
		msg(16'h1840, 16'h0000, 10'h002, 2);
		msg(16'h1844, 16'h2C64, 10'h001, 4);
		foreach (bad2[j]) begin
			msg(16'h1844, bad2[j], 10'h001, 4);
		end
		foreach (fl[j]) begin
			msg(16'h1844, 16'h2C64, fl[j], 4);
		end
		axw(RMIW_OFS_CTRL, 32'h3);
		gb = 1'b1;
		msg(16'h1844, 16'h0000, 10'h000, 4);
		chk("busy", busy_status, 1'b1);
		axw(RMIW_OFS_CTRL, 32'h1);
		print_verdict;
	end
endmodule : tb_rmiw_builder
bind rmiw_builder rmiw_chk i_chk(.mclk, .nrst, .msg_start, .msg_cmd,
	.rx_word, .msg_end, .ram_we, .ram_addr, .ram_wdata, .busy_status);
